// ---- pkg/ocs_regs.svh ----
// offsets, field positions, reset values and timing counts of the block
`ifndef OCS_REGS_SVH
`define OCS_REGS_SVH
`define OCS_CMDSTAT_OFFSET   8'h08
`define OCS_CMDSTAT_RESET    32'h0000_0000
`define OCS_BIT_SWRST        0
`define OCS_BIT_CTRL_FILLED  1
`define OCS_BIT_BULK_FILLED  2
`define OCS_BIT_OWN_REQ      3
`define OCS_SOC_LO           16
`define OCS_SOC_HI           17
`define OCS_ISTAT_OVERRUN    0
`define OCS_ISTAT_OWN_CHG    30
`define OCS_FSTATE_SUSPEND   2'h3
`define OCS_CLK_MHZ          20
`define OCS_SWRST_US         10
`define OCS_SWRST_CYC        (`OCS_SWRST_US * `OCS_CLK_MHZ)
`endif

// ---- pkg/ocs_pkg.sv ----
// types shared by the command and status block
package ocs_pkg;
    // register access request from the driver side
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ocs_req_s;

    // list engine events toward this block
    typedef struct packed {
        logic bulk_head;
        logic bulk_td_found;
        logic ctrl_head;
        logic ctrl_td_found;
        logic sched_overrun;
        logic own_change_done;
    } ocs_evt_s;

    // software reset sequencer states
    typedef enum logic [1:0] {
        OCS_RST_IDLE = 2'b01,
        OCS_RST_BUSY = 2'b10
    } ocs_rst_e;
endpackage : ocs_pkg

// ---- hw/ocs_cmd_status.sv ----
// command and status register with list flags, overrun count, soft reset
`timescale 1ns/10ps
`include "ocs_regs.svh"

// Summary of operation
// R1 - writes set bits written one, bits written zero stay unchanged
// R2 - reads return current value with no side effect
// R3 - overrun increments counter and raises overrun status event
// R4 - overrun counter at bits 17..16, resets zero, wraps at three
// R5 - counter increments even if overrun status already set
// R6 - ownership request bit 3 raises ownership change status bit 30
// R7 - ownership request clears after changeover, stays clear until rewritten
// R8 - software sets bulk filled flag when adding bulk descriptors
// R9 - bulk head: skip if flag zero, else start bulk and clear flag
// R10 - bulk descriptor found sets bulk flag again
// R11 - software sets control filled flag when adding control descriptors
// R12 - control head: skip if zero, else start control and clear flag
// R13 - control descriptor found sets control flag again
// R14 - software reset forces suspend state, keeps routing bit
// R15 - no host bus access starts during software reset
// R16 - software reset ends within 10 us and clears its bit
// R17 - software reset never resets root hub or drives port reset
// R18 - software writes reserved ranges with zero
// R19 - soft reset target is suspend code three, hardware reset differs
// R20 - ownership event raises management irq; reads zero without pin
// R21 - rewriting reset bit during reset only keeps it set
module ocs_cmd_status #(
    parameter bit SMI_PRESENT = 1'b1
) (
    // clock and reset
    input  wire logic            core_clk,
    input  wire logic            rst_n,
    // register access
    input  wire ocs_pkg::ocs_req_s req,
    output logic [31:0]          rdata_ff,
    // list engine events
    input  wire ocs_pkg::ocs_evt_s evt,
    output logic                 bulk_go_ff,
    output logic                 ctrl_go_ff,
    // interrupt status sets and management irq
    output logic                 istat_overrun_set_ff,
    output logic                 istat_own_set_ff,
    input  wire logic            own_chg_enabled,
    output logic                 smi_req_ff,
    // soft reset toward the controller core
    output logic                 sw_reset_active_ff,
    output logic                 force_state_ff,
    output logic [1:0]           force_state_val_ff,
    output logic                 bus_access_block_ff
);
    localparam logic [8:0] SWRST_CYC = 9'(`OCS_SWRST_CYC);

    logic        wr_hit;
    logic        own_req_ff;
    logic        bulk_flag_ff;
    logic        ctrl_flag_ff;
    logic        swrst_ff;
    logic [1:0]  soc_ff;
    logic [8:0]  rst_cnt_ff;
    logic [31:0] cur_val;
    logic        own_rise;
    logic        rst_go;
    ocs_pkg::ocs_rst_e rst_st_ff;
    ocs_pkg::ocs_rst_e nxt_rst_st;

    assign wr_hit = req.wr && (req.addr == `OCS_CMDSTAT_OFFSET);
    assign own_rise = wr_hit && req.wdata[`OCS_BIT_OWN_REQ] && !own_req_ff;
    // soft reset runs in the coming cycle
    assign rst_go = (nxt_rst_st == ocs_pkg::OCS_RST_BUSY);

    // current register image, reserved bits read zero
    always_comb
    begin
        cur_val = `OCS_CMDSTAT_RESET;
        cur_val[`OCS_SOC_HI:`OCS_SOC_LO] = soc_ff;
        cur_val[`OCS_BIT_OWN_REQ]        = own_req_ff;
        cur_val[`OCS_BIT_BULK_FILLED]    = bulk_flag_ff;
        cur_val[`OCS_BIT_CTRL_FILLED]    = ctrl_flag_ff;
        cur_val[`OCS_BIT_SWRST]          = swrst_ff;
    end

    // read data, no state changes on read
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_ff <= 32'h0000_0000;
        else if (req.rd && req.addr == `OCS_CMDSTAT_OFFSET)
            rdata_ff <= cur_val; // R2
        else
            rdata_ff <= 32'h0000_0000;
    end

    // ownership request: write sets, changeover clears, set wins
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            own_req_ff <= 1'b0;
        else if (wr_hit && req.wdata[`OCS_BIT_OWN_REQ])
            own_req_ff <= 1'b1; // R1
        else if (evt.own_change_done || rst_st_ff == ocs_pkg::OCS_RST_BUSY)
            own_req_ff <= 1'b0; // R7
    end

    // ownership change status event and management irq
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            istat_own_set_ff <= 1'b0;
            smi_req_ff       <= 1'b0;
        end
        else
        begin
            istat_own_set_ff <= own_rise && SMI_PRESENT; // R6 R20
            smi_req_ff <= own_rise && SMI_PRESENT && own_chg_enabled; // R20
        end
    end

    // bulk filled flag: software or found descriptor set, head clears
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            bulk_flag_ff <= 1'b0;
        else if ((wr_hit && req.wdata[`OCS_BIT_BULK_FILLED])
                 || evt.bulk_td_found)
            bulk_flag_ff <= 1'b1; // R1 R10
        else if (evt.bulk_head || rst_st_ff == ocs_pkg::OCS_RST_BUSY)
            bulk_flag_ff <= 1'b0; // R9
    end

    // control filled flag, same scheme as bulk
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_flag_ff <= 1'b0;
        else if ((wr_hit && req.wdata[`OCS_BIT_CTRL_FILLED])
                 || evt.ctrl_td_found)
            ctrl_flag_ff <= 1'b1; // R1 R13
        else if (evt.ctrl_head || rst_st_ff == ocs_pkg::OCS_RST_BUSY)
            ctrl_flag_ff <= 1'b0; // R12
    end

    // list start decisions at the list heads
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bulk_go_ff <= 1'b0;
            ctrl_go_ff <= 1'b0;
        end
        else
        begin
            bulk_go_ff <= evt.bulk_head && bulk_flag_ff; // R9
            ctrl_go_ff <= evt.ctrl_head && ctrl_flag_ff; // R12
        end
    end

    // overrun counter and status event, independent of status bit
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            soc_ff               <= 2'h0;
            istat_overrun_set_ff <= 1'b0;
        end
        else
        begin
            if (evt.sched_overrun)
                soc_ff <= soc_ff + 2'h1; // R3 R4 R5
            else if (rst_st_ff == ocs_pkg::OCS_RST_BUSY)
                soc_ff <= 2'h0;
            istat_overrun_set_ff <= evt.sched_overrun; // R3
        end
    end

    // soft reset sequencer state
    always_comb
    begin
        nxt_rst_st = rst_st_ff;
        case (rst_st_ff)
            ocs_pkg::OCS_RST_IDLE:
                if (wr_hit && req.wdata[`OCS_BIT_SWRST])
                    nxt_rst_st = ocs_pkg::OCS_RST_BUSY;
            ocs_pkg::OCS_RST_BUSY:
                if (rst_cnt_ff == SWRST_CYC - 9'h001)
                    nxt_rst_st = ocs_pkg::OCS_RST_IDLE; // R16
            default:
                nxt_rst_st = ocs_pkg::OCS_RST_IDLE;
        endcase
    end

    // sequencer, counter and reset bit; rewrite while busy is ignored
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_st_ff  <= ocs_pkg::OCS_RST_IDLE;
            rst_cnt_ff <= 9'h000;
            swrst_ff   <= 1'b0;
        end
        else
        begin
            rst_st_ff <= nxt_rst_st;
            if (rst_st_ff == ocs_pkg::OCS_RST_BUSY)
                rst_cnt_ff <= rst_cnt_ff + 9'h001; // R21
            else
                rst_cnt_ff <= 9'h000;
            swrst_ff <= rst_go; // R16 R21
        end
    end

    // soft reset outputs; no root hub or port reset output exists
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_reset_active_ff  <= 1'b0;
            force_state_ff      <= 1'b0;
            force_state_val_ff  <= 2'h0;
            bus_access_block_ff <= 1'b0;
        end
        else
        begin
            sw_reset_active_ff  <= rst_go;
            force_state_ff      <= rst_go; // R14
            force_state_val_ff  <= `OCS_FSTATE_SUSPEND; // R19 R17
            bus_access_block_ff <= rst_go; // R15
        end
    end
endmodule : ocs_cmd_status

// ---- sim/ocs_cmd_status_props.sv ----
// assertion checker for the command and status block
`timescale 1ns/10ps
`include "ocs_regs.svh"
module ocs_cmd_status_props #(
    parameter bit SMI_PRESENT = 1'b1
) (
    // clock and reset
    input wire logic              core_clk,
    input wire logic              rst_n,
    // requests and events
    input wire ocs_pkg::ocs_req_s req,
    input wire ocs_pkg::ocs_evt_s evt,
    input wire logic              own_chg_enabled,
    // observed outputs
    input wire logic              bulk_go_ff,
    input wire logic              ctrl_go_ff,
    input wire logic              istat_overrun_set_ff,
    input wire logic              istat_own_set_ff,
    input wire logic              smi_req_ff,
    input wire logic              sw_reset_active_ff,
    input wire logic              force_state_ff,
    input wire logic [1:0]        force_state_val_ff,
    input wire logic              bus_access_block_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // soft reset command taken while idle
    sequence s_rst_cmd;
        req.wr && req.addr == `OCS_CMDSTAT_OFFSET && req.wdata[0]
            && !sw_reset_active_ff;
    endsequence
    // all soft reset levels up together
    sequence s_rst_run;
        sw_reset_active_ff && bus_access_block_ff && force_state_ff;
    endsequence
    a_rst_start: assert property (s_rst_cmd |=> s_rst_run)
        else $error("soft reset did not start");
    a_rst_hold: assert property
        ($rose(sw_reset_active_ff) |-> s_rst_run[*8])
        else $error("bus not blocked during soft reset");
    a_rst_len: assert property
        ($rose(sw_reset_active_ff) |-> ##[1:200] !sw_reset_active_ff)
        else $error("soft reset too long");
    a_fstate_val: assert property
        (force_state_ff |-> force_state_val_ff == `OCS_FSTATE_SUSPEND)
        else $error("forced state not suspend");
    a_overrun_set: assert property
        (evt.sched_overrun |=> istat_overrun_set_ff)
        else $error("overrun status not raised");
    a_bulk_cause: assert property (bulk_go_ff |-> $past(evt.bulk_head))
        else $error("bulk start without head");
    a_ctrl_cause: assert property (ctrl_go_ff |-> $past(evt.ctrl_head))
        else $error("control start without head");
    a_own_cause: assert property
        (istat_own_set_ff |-> SMI_PRESENT
            && $past(req.wr && req.addr == `OCS_CMDSTAT_OFFSET
                     && req.wdata[`OCS_BIT_OWN_REQ]))
        else $error("ownership status without request");
    a_smi_pair: assert property
        (smi_req_ff |-> istat_own_set_ff && $past(own_chg_enabled))
        else $error("management irq without event");
endmodule : ocs_cmd_status_props

bind ocs_cmd_status ocs_cmd_status_props #(.SMI_PRESENT(SMI_PRESENT)) u_props (
    .core_clk(core_clk), .rst_n(rst_n), .req(req), .evt(evt),
    .own_chg_enabled(own_chg_enabled), .bulk_go_ff(bulk_go_ff),
    .ctrl_go_ff(ctrl_go_ff), .istat_overrun_set_ff(istat_overrun_set_ff),
    .istat_own_set_ff(istat_own_set_ff), .smi_req_ff(smi_req_ff),
    .sw_reset_active_ff(sw_reset_active_ff), .force_state_ff(force_state_ff),
    .force_state_val_ff(force_state_val_ff),
    .bus_access_block_ff(bus_access_block_ff));

// ---- sim/tb.sv ----
// self-checking bench for the command and status block
`timescale 1ns/10ps
module tb;
    logic              core_clk, rst_n, own_en;
    ocs_pkg::ocs_req_s req;
    ocs_pkg::ocs_evt_s evt;
    logic [31:0]       rdata;
    logic              bgo, cgo, ovr, own, smi, swr, fst, blk;
    logic [1:0]        fsv;
    int                failures, cmp_count, cyc, n;

    ocs_cmd_status dut (.core_clk(core_clk), .rst_n(rst_n), .req(req),
        .rdata_ff(rdata), .evt(evt), .bulk_go_ff(bgo), .ctrl_go_ff(cgo),
        .istat_overrun_set_ff(ovr), .istat_own_set_ff(own),
        .own_chg_enabled(own_en), .smi_req_ff(smi),
        .sw_reset_active_ff(swr), .force_state_ff(fst),
        .force_state_val_ff(fsv), .bus_access_block_ff(blk));

    // 20 mhz clock
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // hang guard
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            failures++;
            test_done();
        end
    end

    task chk(string nm, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk) #1 req = '{1'b1, 1'b0, a, d};
        @(posedge core_clk) #1 req.wr = 1'b0;
    endtask : wr

    task rd(logic [7:0] a, logic [31:0] exp);
        @(posedge core_clk) #1 req = '{1'b0, 1'b1, a, 32'h0};
        @(posedge core_clk) #1 req.rd = 1'b0;
        chk("rdata", exp, rdata);
    endtask : rd

    task ev(logic [5:0] v);
        @(posedge core_clk) #1 evt = v;
        @(posedge core_clk) #1 evt = '0;
    endtask : ev

    task test_done();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done

    // main sequence
    initial
    begin
        req = '0;
        evt = '0;
        own_en = 1'b1;
        rst_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 rst_n = 1'b1;
        rd(8'h08, 32'h0);
        wr(8'h08, 32'h4);
        wr(8'h08, 32'h2);
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h6);
        rd(8'h08, 32'h6);
        wr(8'h0c, 32'h8);
        rd(8'h0c, 32'h0);
        rd(8'h08, 32'h6);
        // bulk list then control list
        for (n = 0; n < 2; n++)
        begin
            ev(n ? 6'h08 : 6'h20);
            chk("go", 32'h1, n ? cgo : bgo);
            rd(8'h08, n ? 32'h4 : 32'h2);
            ev(n ? 6'h08 : 6'h20);
            chk("go", 32'h0, n ? cgo : bgo);
            ev(n ? 6'h04 : 6'h10);
            rd(8'h08, 32'h6);
        end
        // overrun count wraps after three
        for (n = 1; n < 6; n++)
        begin
            ev(6'h02);
            chk("overrun", 32'h1, ovr);
            rd(8'h08, {14'h0, n[1:0], 16'h0006});
        end
        wr(8'h08, 32'h8);
        chk("own", 32'h1, own);
        chk("smi", 32'h1, smi);
        rd(8'h08, 32'h0001_000e);
        ev(6'h01);
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h0001_0006);
        // masked ownership event: status but no management irq
        own_en = 1'b0;
        wr(8'h08, 32'h8);
        chk("own", 32'h1, own);
        chk("smi", 32'h0, smi);
        ev(6'h01);
        own_en = 1'b1;
        rd(8'h08, 32'h0001_0006);
        // soft reset, rewritten while busy
        wr(8'h08, 32'h1);
        chk("block", 32'h1, blk & fst & swr);
        rd(8'h08, 32'h1);
        wr(8'h08, 32'h1);
        n = 4;
        while (swr === 1'b1 && n < 260)
            @(posedge core_clk) #1 n++;
        chk("duration", 32'h1, n <= 200);
        chk("release", 32'h0, blk | fst | swr);
        rd(8'h08, 32'h0);
        chk("state", 32'h3, fsv);
        test_done();
    end
endmodule : tb
